// ===== pkg/iso_fast_serial_pkg.sv
// Purpose: Shared constants and types for the isolated fast serial port.
// Assumes: One byte frame is a low start bit followed by eight data bits.
// Notes:   Data bits travel most significant bit first in both directions.

package iso_fast_serial_pkg;

  // ==========================================================================
  // Frame layout
  localparam int unsigned DATA_BITS = 8;
  localparam logic [3:0]  LAST_BIT_IDX = 4'h7;
  localparam logic [3:0]  BIT_CNT_RST = 4'h0;
  localparam logic        START_LEVEL = 1'b0;
  localparam logic        IDLE_LEVEL = 1'b1;

  // ==========================================================================
  // Receive buffer
  localparam logic [1:0]  BUF_DEPTH = 2'h2;
  localparam logic [1:0]  BUF_CNT_RST = 2'h0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [1:0]  SYNC_RST = 2'h3;

  typedef enum logic {RX_IDLE, RX_DATA} rx_state_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;

endpackage

// ===== verilog/isolated_fast_serial_port.sv
// Purpose: Device end of the isolated fast serial link and the
//          send-now / wake strobe decoder.
// Assumes: clk at 125 MHz; the link clock is at most a quarter of clk.
// Notes:   The link input pins and the wake pin pass a two-stage synchroniser before use; the USB state inputs do not.
//
// Overview of operation
// - Exactly four link wires: data and clock in, data and clear-to-send out.
// - Bits shift in and out only on edges of the peripheral's clock.
// - Clear-to-send is low while a byte waits to go, high otherwise.
// - Wake strobe while suspended with remote wake enabled requests resume.
// - Wake strobe while awake requests a flush of the receive buffer on next bulk-in.

`timescale 1ns/1ps

module isolated_fast_serial_port (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Isolated link pins
  input  wire logic       iso_serial_clock_in,
  input  wire logic       iso_serial_data_in,
  output logic            iso_serial_data_out,
  output logic            iso_clear_to_send_n,
  // Strobe pin and USB state
  input  wire logic       send_now_wake_n,
  input  wire logic       usb_power_enable_n,
  input  wire logic       remote_wake_enable,
  output logic            resume_request,
  output logic            flush_request,
  // Bytes to send to the peripheral
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  // Bytes received from the peripheral
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       rx_ready,
  output logic            rx_overrun
);

  // ==========================================================================
  // Pin synchronisers and edge detection
  logic [1:0] sclk_sync_reg;
  logic [1:0] din_sync_reg;
  logic [1:0] wake_sync_reg;
  logic       sclk_prev_reg, wake_prev_reg;
  logic       sclk_rise, sclk_fall, wake_fall;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_sync_reg <= iso_fast_serial_pkg::SYNC_RST;
      din_sync_reg  <= iso_fast_serial_pkg::SYNC_RST;
      wake_sync_reg <= iso_fast_serial_pkg::SYNC_RST;
      sclk_prev_reg <= 1'b1;
      wake_prev_reg <= 1'b1;
    end else begin
      // The link's two input wires and the wake pin are sampled here.
      sclk_sync_reg <= {sclk_sync_reg[0], iso_serial_clock_in};
      din_sync_reg  <= {din_sync_reg[0], iso_serial_data_in};
      wake_sync_reg <= {wake_sync_reg[0], send_now_wake_n};
      sclk_prev_reg <= sclk_sync_reg[1];
      wake_prev_reg <= wake_sync_reg[1];
    end
  end

  // The peripheral's clock is the only timing source for the bit shifts.
  assign sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
  assign sclk_fall = ~sclk_sync_reg[1] & sclk_prev_reg;
  assign wake_fall = ~wake_sync_reg[1] & wake_prev_reg;

  // ==========================================================================
  // Send-now / wake strobe
  logic resume_reg, resume_next;
  logic flush_reg, flush_next;

  always_comb begin
    resume_next = wake_fall & usb_power_enable_n & remote_wake_enable;
    flush_next  = wake_fall & ~usb_power_enable_n;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resume_reg <= 1'b0;
      flush_reg  <= 1'b0;
    end else begin
      resume_reg <= resume_next;
      flush_reg  <= flush_next;
    end
  end

  // ==========================================================================
  // Transmit path: one holding byte and a shifter
  iso_fast_serial_pkg::tx_state_t tx_state_reg, tx_state_next;
  logic       tx_full_reg, tx_full_next;
  logic [7:0] tx_hold_reg, tx_hold_next;
  logic [7:0] tx_shift_reg, tx_shift_next;
  logic [3:0] tx_cnt_reg, tx_cnt_next;
  logic       dout_reg, dout_next;
  logic       cts_n_reg, cts_n_next;
  logic       tx_ready_reg, tx_ready_next;

  always_comb begin
    tx_state_next = tx_state_reg;
    tx_full_next  = tx_full_reg;
    tx_hold_next  = tx_hold_reg;
    tx_shift_next = tx_shift_reg;
    tx_cnt_next   = tx_cnt_reg;
    dout_next     = dout_reg;
    unique case (tx_state_reg)
      iso_fast_serial_pkg::TX_IDLE: begin
        if (tx_full_reg && sclk_fall) begin
          dout_next     = iso_fast_serial_pkg::START_LEVEL;
          tx_shift_next = tx_hold_reg;
          tx_cnt_next   = iso_fast_serial_pkg::BIT_CNT_RST;
          tx_full_next  = 1'b0;
          tx_state_next = iso_fast_serial_pkg::TX_SHIFT;
        end
      end
      iso_fast_serial_pkg::TX_SHIFT: begin
        if (sclk_fall) begin
          if (tx_cnt_reg <= iso_fast_serial_pkg::LAST_BIT_IDX) begin
            dout_next     = tx_shift_reg[7];
            tx_shift_next = {tx_shift_reg[6:0], 1'b0};
            tx_cnt_next   = tx_cnt_reg + 4'h1;
          end else begin
            dout_next     = iso_fast_serial_pkg::IDLE_LEVEL;
            tx_state_next = iso_fast_serial_pkg::TX_IDLE;
          end
        end
      end
    endcase
    if (tx_valid && tx_ready_reg) begin
      tx_hold_next = tx_data;
      tx_full_next = 1'b1;
    end
    // Clear-to-send follows the holding byte; a byte already being shifted
    // no longer counts as waiting.
    cts_n_next    = ~tx_full_next;
    tx_ready_next = ~tx_full_next;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_state_reg <= iso_fast_serial_pkg::TX_IDLE;
      tx_full_reg  <= 1'b0;
      tx_hold_reg  <= iso_fast_serial_pkg::BYTE_RST;
      tx_shift_reg <= iso_fast_serial_pkg::BYTE_RST;
      tx_cnt_reg   <= iso_fast_serial_pkg::BIT_CNT_RST;
      dout_reg     <= iso_fast_serial_pkg::IDLE_LEVEL;
      cts_n_reg    <= 1'b1;
      tx_ready_reg <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_full_reg  <= tx_full_next;
      tx_hold_reg  <= tx_hold_next;
      tx_shift_reg <= tx_shift_next;
      tx_cnt_reg   <= tx_cnt_next;
      dout_reg     <= dout_next;
      cts_n_reg    <= cts_n_next;
      tx_ready_reg <= tx_ready_next;
    end
  end

  // ==========================================================================
  // Receive path: deserialiser into a two-entry buffer
  // The peripheral has no way to be held off, so the buffer only absorbs a
  // short stall by the reader; a longer one drops the newest byte.
  iso_fast_serial_pkg::rx_state_t rx_state_reg, rx_state_next;
  logic [7:0] rx_shift_reg, rx_shift_next;
  logic [3:0] rx_cnt_reg, rx_cnt_next;
  logic [7:0] buf_reg [2], buf_next [2];
  logic [1:0] buf_cnt_reg, buf_cnt_next;
  logic       rx_valid_reg, rx_valid_next;
  logic       ovr_reg, ovr_next;
  logic       push, pop;
  logic [1:0] after_pop;

  always_comb begin
    rx_state_next = rx_state_reg;
    rx_shift_next = rx_shift_reg;
    rx_cnt_next   = rx_cnt_reg;
    push          = 1'b0;
    unique case (rx_state_reg)
      iso_fast_serial_pkg::RX_IDLE: begin
        if (sclk_rise &&
            din_sync_reg[1] == iso_fast_serial_pkg::START_LEVEL) begin
          rx_cnt_next   = iso_fast_serial_pkg::BIT_CNT_RST;
          rx_state_next = iso_fast_serial_pkg::RX_DATA;
        end
      end
      iso_fast_serial_pkg::RX_DATA: begin
        if (sclk_rise) begin
          rx_shift_next = {rx_shift_reg[6:0], din_sync_reg[1]};
          rx_cnt_next   = rx_cnt_reg + 4'h1;
          if (rx_cnt_reg == iso_fast_serial_pkg::LAST_BIT_IDX) begin
            push          = 1'b1;
            rx_state_next = iso_fast_serial_pkg::RX_IDLE;
          end
        end
      end
    endcase
    pop       = rx_ready && (buf_cnt_reg != iso_fast_serial_pkg::BUF_CNT_RST);
    after_pop = buf_cnt_reg - {1'b0, pop};
    buf_next[0] = pop ? buf_reg[1] : buf_reg[0];
    buf_next[1] = buf_reg[1];
    buf_cnt_next = after_pop;
    ovr_next     = 1'b0;
    if (push) begin
      if (after_pop == iso_fast_serial_pkg::BUF_DEPTH) begin
        ovr_next = 1'b1;
      end else begin
        buf_next[after_pop[0]] = rx_shift_next;
        buf_cnt_next           = after_pop + 2'h1;
      end
    end
    rx_valid_next = (buf_cnt_next != iso_fast_serial_pkg::BUF_CNT_RST);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_state_reg <= iso_fast_serial_pkg::RX_IDLE;
      rx_shift_reg <= iso_fast_serial_pkg::BYTE_RST;
      rx_cnt_reg   <= iso_fast_serial_pkg::BIT_CNT_RST;
      buf_reg[0]   <= iso_fast_serial_pkg::BYTE_RST;
      buf_reg[1]   <= iso_fast_serial_pkg::BYTE_RST;
      buf_cnt_reg  <= iso_fast_serial_pkg::BUF_CNT_RST;
      rx_valid_reg <= 1'b0;
      ovr_reg      <= 1'b0;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_shift_reg <= rx_shift_next;
      rx_cnt_reg   <= rx_cnt_next;
      buf_reg[0]   <= buf_next[0];
      buf_reg[1]   <= buf_next[1];
      buf_cnt_reg  <= buf_cnt_next;
      rx_valid_reg <= rx_valid_next;
      ovr_reg      <= ovr_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign iso_serial_data_out = dout_reg;
  assign iso_clear_to_send_n = cts_n_reg;
  assign tx_ready            = tx_ready_reg;
  assign resume_request      = resume_reg;
  assign flush_request       = flush_reg;
  assign rx_valid            = rx_valid_reg;
  assign rx_data             = buf_reg[0];
  assign rx_overrun          = ovr_reg;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_dout_on_fall: assert property (
    $changed(iso_serial_data_out) |-> $past(sclk_fall))
    else $error("data out changed without a link clock falling edge");

  a_rx_on_rise: assert property (
    (rx_state_reg != $past(rx_state_reg)) |-> $past(sclk_rise))
    else $error("receive state moved without a link clock rising edge");

  a_start_bit_out: assert property (
    (tx_state_reg == iso_fast_serial_pkg::TX_IDLE && tx_full_reg && sclk_fall)
      |=> (iso_serial_data_out == 1'b0) ##0 tx_state_reg != 1'b0)
    else $error("start bit not sent on first falling edge");

  a_cts_low_load: assert property (
    (tx_valid && tx_ready) |=> !iso_clear_to_send_n)
    else $error("clear to send not low after a byte was loaded");

  a_cts_high_empty: assert property (
    (!tx_full_reg && !$past(tx_valid && tx_ready)) |-> iso_clear_to_send_n)
    else $error("clear to send low with no byte waiting");

  a_resume_req: assert property (
    (wake_fall && usb_power_enable_n && remote_wake_enable)
      |=> resume_request ##1 !resume_request)
    else $error("resume not requested as a single pulse");

  a_no_resume_awake: assert property (
    resume_request |-> $past(usb_power_enable_n) && $past(remote_wake_enable))
    else $error("resume requested while awake or wake disabled");

  a_flush_req: assert property (
    (wake_fall && !usb_power_enable_n) |=> flush_request ##1 !flush_request)
    else $error("flush not requested as a single pulse");

  c_byte_sent: cover property (
    tx_state_reg == iso_fast_serial_pkg::TX_SHIFT ##1
    tx_state_reg == iso_fast_serial_pkg::TX_IDLE);
  c_buf_full: cover property (buf_cnt_reg == iso_fast_serial_pkg::BUF_DEPTH);
  c_resume: cover property (resume_request);
  c_flush: cover property (flush_request);

endmodule // isolated_fast_serial_port

// ===== tb/iso_peripheral_model.sv
// Purpose: Behavioural isolated peripheral that clocks the serial link.
// Assumes: Link clock period of 64 ns; the clock stands high between frames.
// Notes:   Device bits are read on the falling edge after their launch.

`timescale 1ns/1ps

module iso_peripheral_model (
  // Link wires to the device
  output logic      iso_serial_clock_in,
  output logic      iso_serial_data_in,
  input  wire logic iso_serial_data_out,
  input  wire logic iso_clear_to_send_n
);
  // ==========================================================================
  // Frame engine
  initial begin
    iso_serial_clock_in = 1'b1;
    iso_serial_data_in  = 1'b1;
  end

  // Reading at the next fall avoids racing the device's 2-3 cycle launch.
  task automatic frame(input logic [7:0] send, output logic start_seen,
                       output logic [7:0] got);
    logic [8:0] shift;
    shift = {1'b0, send};
    got = 8'h00;
    start_seen = 1'b1;
    for (int k = 0; k < 10; k++) begin
      iso_serial_clock_in = 1'b0;
      if (k == 1) start_seen = iso_serial_data_out;
      if (k > 1) got = {got[6:0], iso_serial_data_out};
      iso_serial_data_in = (k < 9) ? shift[8 - k] : 1'b1;
      #32;
      iso_serial_clock_in = 1'b1;
      #32;
    end
  endtask
endmodule // iso_peripheral_model

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the isolated fast serial port.
// Assumes: Inputs change 1 ns after the rising edge of clk.
// Notes:   Output pulses are tallied by a monitor and compared by delta.

`timescale 1ns/1ps

module testbench;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       sclk, sdin, sdout, cts_n;
  logic       wake_n = 1'b1, pwr_n = 1'b0, rwake = 1'b0;
  logic       resume, flush, overrun;
  logic       tx_valid = 1'b0, tx_ready, rx_valid, rx_ready = 1'b0;
  logic [7:0] tx_data = 8'h00, rx_data;
  int         n_mismatch = 0, check_count = 0;
  int         n_res = 0, n_flush = 0, n_over = 0;

  always #4 clk = ~clk;

  isolated_fast_serial_port isolated_fast_serial_port_inst (
    .clk(clk), .sys_rst(sys_rst),
    .iso_serial_clock_in(sclk), .iso_serial_data_in(sdin),
    .iso_serial_data_out(sdout), .iso_clear_to_send_n(cts_n),
    .send_now_wake_n(wake_n), .usb_power_enable_n(pwr_n),
    .remote_wake_enable(rwake), .resume_request(resume),
    .flush_request(flush), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .rx_overrun(overrun));

  iso_peripheral_model iso_peripheral_model_inst (
    .iso_serial_clock_in(sclk), .iso_serial_data_in(sdin),
    .iso_serial_data_out(sdout), .iso_clear_to_send_n(cts_n));

  always @(negedge clk) begin
    if (resume === 1'b1) n_res++;
    if (flush === 1'b1) n_flush++;
    if (overrun === 1'b1) n_over++;
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic load_tx(logic [7:0] b);
    logic r;
    tx_valid = 1'b1;
    tx_data  = b;
    for (int i = 0; i < 200; i++) begin
      r = tx_ready;
      @(posedge clk);
      #1;
      if (r === 1'b1) break;
    end
    tx_valid = 1'b0;
    check("tx_ready", {7'h0, r}, 8'h01);
  endtask

  task automatic pop_rx(logic [7:0] exp);
    for (int i = 0; i < 50 && rx_valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check("rx_valid", {7'h0, rx_valid}, 8'h01);
    check("rx_data", rx_data, exp);
    rx_ready = 1'b1;
    @(posedge clk);
    #1;
    rx_ready = 1'b0;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic duplex_frame();
    logic       st;
    logic [7:0] got;
    check("cts idle", {7'h0, cts_n}, 8'h01);
    load_tx(8'ha5);
    @(posedge clk);
    #1;
    check("cts waiting", {7'h0, cts_n}, 8'h00);
    iso_peripheral_model_inst.frame(8'h96, st, got);
    check("start bit", {7'h0, st}, 8'h00);
    check("tx byte", got, 8'ha5);
    check("cts freed", {7'h0, cts_n}, 8'h01);
    pop_rx(8'h96);
  endtask

  task automatic stall_and_overrun();
    logic       st;
    logic [7:0] got;
    int         o;
    o = n_over;
    iso_peripheral_model_inst.frame(8'h3c, st, got);
    iso_peripheral_model_inst.frame(8'hc3, st, got);
    iso_peripheral_model_inst.frame(8'h81, st, got);
    check("no start unloaded", {7'h0, st}, 8'h01);
    check("idle data out", got, 8'hff);
    check("overrun", 8'(n_over - o), 8'h01);
    pop_rx(8'h3c);
    pop_rx(8'hc3);
    check("drained", {7'h0, rx_valid}, 8'h00);
  endtask

  task automatic strobes();
    logic [2:0] tbl [4] = '{3'b110, 3'b100, 3'b001, 3'b011};
    int         r, f;
    foreach (tbl[i]) begin
      pwr_n = tbl[i][2];
      rwake = tbl[i][1];
      r = n_res;
      f = n_flush;
      repeat (4) @(posedge clk);
      #1;
      wake_n = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      wake_n = 1'b1;
      repeat (8) @(posedge clk);
      #1;
      check("resume", 8'(n_res - r), {7'h0, tbl[i][1] & tbl[i][2]});
      check("flush", 8'(n_flush - f), {7'h0, ~tbl[i][2]});
    end
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("reset data out", {7'h0, sdout}, 8'h01);
    check("reset rx_valid", {7'h0, rx_valid}, 8'h00);
    duplex_frame();
    stall_and_overrun();
    strobes();
    close_out();
  end

  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
endmodule // testbench
